// ==== gddc_pkg.sv ====
`default_nettype none

package gddc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] GDDC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] GDDC_OFS_PRI_INC = 8'h04;
    localparam logic [7:0] GDDC_OFS_AUX_INC = 8'h08;
    localparam logic [7:0] GDDC_OFS_PRI_THR = 8'h0c;
    localparam logic [7:0] GDDC_OFS_AUX_THR = 8'h10;
    localparam logic [7:0] GDDC_OFS_STATUS  = 8'h14;

    localparam int GDDC_CTRL_PRI_SEL_BIT = 0;
    localparam int GDDC_CTRL_AUX_SEL_BIT = 1;
    localparam int GDDC_THR0_LSB         = 0;
    localparam int GDDC_THR1_LSB         = 10;
    localparam int GDDC_THR2_LSB         = 20;
    localparam int GDDC_STAT_PEND_LSB    = 0;
    localparam int GDDC_STAT_PRI_PH_LSB  = 8;
    localparam int GDDC_STAT_AUX_PH_LSB  = 16;

    localparam logic [9:0] GDDC_THR0_RST = 10'h047;
    localparam logic [9:0] GDDC_THR1_RST = 10'h08f;
    localparam logic [9:0] GDDC_THR2_RST = 10'h0d7;
    localparam logic [6:0] GDDC_INC_RST  = 7'h00;

    // ****************************************************************
    // Structure
    // ****************************************************************
    localparam int         GDDC_LANES    = 5;
    localparam int         GDDC_TICKS    = 3;
    localparam int         GDDC_TAPS     = 15;
    localparam logic [3:0] GDDC_WR_START = 4'h0;
    localparam logic [3:0] GDDC_RD_START = 4'h8;
    localparam logic [3:0] GDDC_RD_STEP  = 4'h5;

    localparam int GDDC_TAP [0:14] = '{-1, -1, 0, 1, 3, 5, 6, 7, 6, 5, 3, 1, 0, -1, -1};

    // Quarter wave of the cosine in 128 phase steps, scaled by 256.
    localparam int GDDC_COS [0:32] = '{256, 256, 255, 253, 251, 248, 245, 241, 237, 231,
                                       226, 220, 213, 206, 198, 190, 181, 172, 162, 152,
                                       142, 132, 121, 109, 98, 86, 74, 62, 50, 38, 25, 13, 0};

    typedef struct packed {
        logic [2:0] i;
        logic [2:0] q;
    } gddc_iq_t;

    typedef struct packed {
        logic [9:0] t2;
        logic [9:0] t1;
        logic [9:0] t0;
    } gddc_thr_t;

    // Rounds value/256 to the nearest odd level and returns the offset code.
    function automatic logic [2:0] gddc_round(input int v);
        int f;
        f = (v >>> 9) + 4;
        if (f < 0) begin
            f = 0;
        end
        if (f > 7) begin
            f = 7;
        end
        return 3'(f);
    endfunction : gddc_round

    // Rotates one real sample by minus the phase and snaps it to the grid.
    function automatic gddc_iq_t gddc_mix(input logic [2:0] code, input logic [6:0] ph);
        gddc_iq_t r;
        int       x;
        int       c;
        int       s;
        int       k;
        x = 2 * int'(code) - 7;
        k = int'(ph[4:0]);
        case (ph[6:5])
            2'd0: begin
                c = GDDC_COS[k];
                s = GDDC_COS[32 - k];
            end
            2'd1: begin
                c = -GDDC_COS[32 - k];
                s = GDDC_COS[k];
            end
            2'd2: begin
                c = -GDDC_COS[k];
                s = -GDDC_COS[32 - k];
            end
            default: begin
                c = GDDC_COS[32 - k];
                s = -GDDC_COS[k];
            end
        endcase
        r.i = gddc_round(x * c);
        r.q = gddc_round(-(x * s));
        return r;
    endfunction : gddc_mix

endpackage : gddc_pkg

`default_nettype wire

// ==== gddc_fir.sv ====
`timescale 1ns/1ps
`default_nettype none

module gddc_fir (
    input  wire logic              clk,     // Core clock
    input  wire logic              resetn,  // Asynchronous reset, active low
    input  wire logic [14:0]       codes,   // Five lane codes, lane 0 oldest
    output logic signed [9:0]      filt     // Decimated filter output
);

    logic signed [4:0] lv [0:4];
    logic signed [9:0] part [0:2];
    logic signed [9:0] s1_r;
    logic signed [9:0] s2_r;
    logic signed [9:0] filt_r;

    // ****************************************************************
    // Polyphase partial sums, one block of five taps each
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            lv[i] = 5'($signed({1'b0, codes[3*i +: 3], 1'b0})) - 5'sd7;
        end
        for (int j = 0; j < 3; j++) begin
            part[j] = '0;
            for (int i = 0; i < 5; i++) begin
                part[j] = part[j] + 10'(gddc_pkg::GDDC_TAP[5*j + 4 - i] * int'(lv[i]));
            end
        end
    end

    // Transposed form keeps the adder chain short: one block add per stage.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s2_r   <= '0;
            s1_r   <= '0;
            filt_r <= '0;
        end else begin
            s2_r   <= part[2];
            s1_r   <= part[1] + s2_r;
            filt_r <= part[0] + s1_r;
        end
    end

    assign filt = filt_r;

endmodule : gddc_fir

`default_nettype wire

// ==== gddc_requant.sv ====
`timescale 1ns/1ps
`default_nettype none

module gddc_requant (
    input  wire logic              clk,     // Core clock
    input  wire logic              resetn,  // Asynchronous reset, active low
    input  wire logic signed [9:0] filt,    // Filtered value
    input  wire gddc_pkg::gddc_thr_t thr,   // Three thresholds
    output logic [2:0]             code     // Offset coded level
);

    logic       neg;
    logic [9:0] mag;
    logic [8:0] m9;
    logic [1:0] step;
    logic [2:0] code_r;

    assign neg  = filt[9];
    assign mag  = neg ? 10'(-filt) : 10'(filt);
    // Magnitude stays within 287, so nine bits of each threshold decide.
    assign m9   = mag[8:0];
    assign step = (m9 > thr.t2[8:0]) ? 2'd3 :
                  (m9 > thr.t1[8:0]) ? 2'd2 :
                  (m9 > thr.t0[8:0]) ? 2'd1 : 2'd0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_r <= 3'h4;
        end else begin
            code_r <= neg ? 3'(3'h3 - {1'b0, step}) : 3'(3'h4 + {1'b0, step});
        end
    end

    assign code = code_r;

endmodule : gddc_requant

`default_nettype wire

// ==== gddc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module gddc_top (
    input  wire logic        CLK,            // Core clock
    input  wire logic        RESETN,         // Asynchronous reset, active low
    input  wire logic        PSEL,           // APB select
    input  wire logic        PENABLE,        // APB enable
    input  wire logic        PWRITE,         // APB write
    input  wire logic [7:0]  PADDR,          // APB byte address
    input  wire logic [31:0] PWDATA,         // APB write data
    output logic      [31:0] PRDATA,         // APB read data
    output logic             PREADY,         // APB ready
    output logic             PSLVERR,        // APB error on unmapped address
    input  wire logic [17:0] OWN_SAMPLES,    // Own A/B pairs, tick 0 in low bits
    input  wire logic [1:0]  OWN_TICKS,      // Half-sample ticks this cycle, 0 to 3
    input  wire logic [17:0] PREV_SAMPLES,   // Preceding module A/B pairs
    input  wire logic [1:0]  PREV_TICKS,     // Preceding module tick count
    input  wire logic        IS_FIRST_MODULE,// High in the first input module
    input  wire logic        MEAS_EPOCH,     // Measurement epoch pulse
    output logic      [2:0]  PRI_I,          // Primary in-phase to beam forming
    output logic      [2:0]  PRI_Q,          // Primary quadrature to beam forming
    output logic      [2:0]  AUX_I,          // Auxiliary in-phase to channels
    output logic      [2:0]  AUX_Q           // Auxiliary quadrature to channels
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [1:0]           sel_r;
    logic [6:0]           inc_shadow_r [0:1];
    logic [6:0]           inc_act_r    [0:1];
    logic [1:0]           pend_r;
    logic [1:0]           pend_nxt;
    gddc_pkg::gddc_thr_t  thr_r        [0:1];
    logic [6:0]           acc_r        [0:1];
    logic [31:0]          prdata_r;
    logic                 pready_r;
    logic                 pslverr_r;

    logic                 setup;
    logic                 wr_en;
    logic                 hit_ctrl;
    logic                 hit_pinc;
    logic                 hit_ainc;
    logic                 hit_pthr;
    logic                 hit_athr;
    logic                 hit_stat;
    logic                 mapped;
    logic [1:0]           inc_wr;
    logic [31:0]          rd_mux;
    logic [31:0]          status;
    gddc_pkg::gddc_thr_t  wthr;

    assign setup    = PSEL && !PENABLE;
    assign wr_en    = PSEL && PENABLE && pready_r && PWRITE;
    assign hit_ctrl = (PADDR == gddc_pkg::GDDC_OFS_CTRL);
    assign hit_pinc = (PADDR == gddc_pkg::GDDC_OFS_PRI_INC);
    assign hit_ainc = (PADDR == gddc_pkg::GDDC_OFS_AUX_INC);
    assign hit_pthr = (PADDR == gddc_pkg::GDDC_OFS_PRI_THR);
    assign hit_athr = (PADDR == gddc_pkg::GDDC_OFS_AUX_THR);
    assign hit_stat = (PADDR == gddc_pkg::GDDC_OFS_STATUS);
    assign mapped   = hit_ctrl || hit_pinc || hit_ainc || hit_pthr || hit_athr || hit_stat;
    assign inc_wr   = {wr_en && hit_ainc, wr_en && hit_pinc};
    assign wthr     = gddc_pkg::gddc_thr_t'(PWDATA[29:0]);

    assign status = {9'h0, acc_r[1], 1'b0, acc_r[0], 6'h0, pend_r};

    assign rd_mux = hit_ctrl ? {30'h0, sel_r} :
                    hit_pinc ? {25'h0, inc_shadow_r[0]} :
                    hit_ainc ? {25'h0, inc_shadow_r[1]} :
                    hit_pthr ? {2'h0, thr_r[0]} :
                    hit_athr ? {2'h0, thr_r[1]} :
                    hit_stat ? status : 32'h0;

    // Pending is set by a write and cleared by the epoch; a write in the
    // epoch cycle keeps it set, so the new increment waits one more epoch.
    assign pend_nxt = inc_wr | (pend_r & {2{~MEAS_EPOCH}});

    // Ready is given in the first access cycle, so every transfer has no wait.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= PWRITE ? 32'h0 : rd_mux;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sel_r           <= 2'h0;
            inc_shadow_r[0] <= gddc_pkg::GDDC_INC_RST;
            inc_shadow_r[1] <= gddc_pkg::GDDC_INC_RST;
            thr_r[0]        <= {gddc_pkg::GDDC_THR2_RST, gddc_pkg::GDDC_THR1_RST,
                                gddc_pkg::GDDC_THR0_RST};
            thr_r[1]        <= {gddc_pkg::GDDC_THR2_RST, gddc_pkg::GDDC_THR1_RST,
                                gddc_pkg::GDDC_THR0_RST};
            pend_r          <= 2'h0;
        end else begin
            pend_r <= pend_nxt;
            if (wr_en && hit_ctrl) begin
                sel_r <= PWDATA[1:0];
            end
            if (inc_wr[0]) begin
                inc_shadow_r[0] <= PWDATA[6:0];
            end
            if (inc_wr[1]) begin
                inc_shadow_r[1] <= PWDATA[6:0];
            end
            if (wr_en && hit_pthr) begin
                thr_r[0] <= wthr;
            end
            if (wr_en && hit_athr) begin
                thr_r[1] <= wthr;
            end
        end
    end

    assign PRDATA  = prdata_r;
    assign PREADY  = pready_r;
    assign PSLVERR = pslverr_r;

    // ****************************************************************
    // Two to five converters, one per source stream
    // ****************************************************************
    logic [17:0] src_samples [0:1];
    logic [1:0]  src_ticks   [0:1];
    logic [14:0] lanes_r     [0:1];

    assign src_samples[0] = OWN_SAMPLES;
    assign src_samples[1] = PREV_SAMPLES;
    assign src_ticks[0]   = OWN_TICKS;
    assign src_ticks[1]   = PREV_TICKS;

    // Sources run on a shared phase-locked half-sample rate; a drifting
    // rate would let the pointers collide, which is not detected.
    for (genvar s = 0; s < 2; s++) begin : g_t2f
        logic [2:0] buf_r [0:15];
        logic [3:0] wp_r;
        logic [3:0] rp_r;
        logic [3:0] wp_adv;

        assign wp_adv = 4'({src_ticks[s], 1'b0});

        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                for (int k = 0; k < 16; k++) begin
                    buf_r[k] <= 3'h0;
                end
                wp_r <= gddc_pkg::GDDC_WR_START;
            end else begin
                for (int t = 0; t < gddc_pkg::GDDC_TICKS; t++) begin
                    if (t < int'(src_ticks[s])) begin
                        buf_r[4'(wp_r + 4'(2*t))]     <= src_samples[s][6*t +: 3];
                        buf_r[4'(wp_r + 4'(2*t + 1))] <= src_samples[s][6*t + 3 +: 3];
                    end
                end
                wp_r <= 4'(wp_r + wp_adv);
            end
        end

        // Starting eight entries behind the writer gives the fixed delay.
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                rp_r       <= gddc_pkg::GDDC_RD_START;
                lanes_r[s] <= 15'h0;
            end else begin
                for (int i = 0; i < gddc_pkg::GDDC_LANES; i++) begin
                    lanes_r[s][3*i +: 3] <= buf_r[4'(rp_r + 4'(i))];
                end
                rp_r <= 4'(rp_r + gddc_pkg::GDDC_RD_STEP);
            end
        end
    end

    // ****************************************************************
    // Converters: oscillator, mixer, filter and re-quantizer
    // ****************************************************************
    logic [2:0] out_i [0:1];
    logic [2:0] out_q [0:1];

    for (genvar c = 0; c < 2; c++) begin : g_conv
        logic                src_sel;
        logic [14:0]         lanes;
        logic [6:0]          step5;
        logic                load;
        gddc_pkg::gddc_iq_t  mix_r [0:4];
        logic [14:0]         i_codes;
        logic [14:0]         q_codes;
        logic signed [9:0]   filt_i;
        logic signed [9:0]   filt_q;

        // Slaving is refused in the first module.
        assign src_sel = sel_r[c] && !IS_FIRST_MODULE;
        assign lanes   = src_sel ? lanes_r[1] : lanes_r[0];
        assign load    = MEAS_EPOCH && pend_r[c];
        assign step5   = 7'(inc_act_r[c] * 7'd5);

        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                inc_act_r[c] <= gddc_pkg::GDDC_INC_RST;
                acc_r[c]     <= 7'h0;
            end else if (load) begin
                inc_act_r[c] <= inc_shadow_r[c];
                acc_r[c]     <= 7'h0;
            end else begin
                acc_r[c]     <= 7'(acc_r[c] + step5);
            end
        end

        // The table is small enough to evaluate as constant logic per lane.
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                for (int i = 0; i < gddc_pkg::GDDC_LANES; i++) begin
                    mix_r[i] <= '{i: 3'h4, q: 3'h4};
                end
            end else begin
                for (int i = 0; i < gddc_pkg::GDDC_LANES; i++) begin
                    mix_r[i] <= gddc_pkg::gddc_mix(lanes[3*i +: 3],
                                7'(acc_r[c] + 7'(inc_act_r[c] * 7'(i))));
                end
            end
        end

        assign i_codes = {mix_r[4].i, mix_r[3].i, mix_r[2].i, mix_r[1].i, mix_r[0].i};
        assign q_codes = {mix_r[4].q, mix_r[3].q, mix_r[2].q, mix_r[1].q, mix_r[0].q};

        gddc_fir u_fir_i (
            .clk    (CLK),
            .resetn (RESETN),
            .codes  (i_codes),
            .filt   (filt_i)
        );

        gddc_fir u_fir_q (
            .clk    (CLK),
            .resetn (RESETN),
            .codes  (q_codes),
            .filt   (filt_q)
        );

        gddc_requant u_rq_i (
            .clk    (CLK),
            .resetn (RESETN),
            .filt   (filt_i),
            .thr    (thr_r[c]),
            .code   (out_i[c])
        );

        gddc_requant u_rq_q (
            .clk    (CLK),
            .resetn (RESETN),
            .filt   (filt_q),
            .thr    (thr_r[c]),
            .code   (out_q[c])
        );
    end

    // Both outputs leave the re-quantizer flops with identical latency.
    assign PRI_I = out_i[0];
    assign PRI_Q = out_q[0];
    assign AUX_I = out_i[1];
    assign AUX_Q = out_q[1];

endmodule : gddc_top

`default_nettype wire

// ==== gddc_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module gddc_top_properties (
    input wire logic        CLK,     // Core clock
    input wire logic        RESETN,  // Reset, active low
    input wire logic        PSEL,    // APB select
    input wire logic        PENABLE, // APB enable
    input wire logic        PWRITE,  // APB write
    input wire logic [31:0] PRDATA,  // APB read data
    input wire logic        PREADY,  // APB ready
    input wire logic        PSLVERR  // APB error
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE && PREADY;
    endsequence
    a_ready_next: assert property (s_setup |=> PREADY) else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready long");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
    a_idle_quiet: assert property (!PSEL |=> !PREADY) else $error("idle ready");
    a_err_ready: assert property (PSLVERR |-> PREADY) else $error("lone error");
    a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("error read not zero");
    a_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved");
    a_transfer_end: assert property (s_setup ##1 s_access |=> !PREADY)
        else $error("transfer did not end");
endmodule : gddc_top_properties
bind gddc_top gddc_top_properties i_props (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// ==== gddc_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Converter that sends one constant code; idle tick slots carry the inverse.
module gddc_adc_model #(
    parameter logic [2:0] CODE = 3'h7
) (
    input  wire logic        clk,     // Core clock
    input  wire logic        resetn,  // Reset, active low
    output logic      [17:0] samples, // A/B pairs per tick
    output logic      [1:0]  ticks    // Ticks this cycle
);
    logic odd_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) odd_r <= 1'b0;
        else odd_r <= ~odd_r;
    end
    assign ticks   = odd_r ? 2'h3 : 2'h2;
    assign samples = {odd_r ? {CODE, CODE} : {~CODE, ~CODE}, {4{CODE}}};
endmodule : gddc_adc_model
`default_nettype wire

// ==== gddc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module gddc_top_tb;
    logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IS_FIRST, EPOCH, er;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [17:0] own_s, prev_s;
    logic [1:0] own_t, prev_t;
    logic [2:0] pi, pq, ai, aq;
    int bad_count, checks_done, cycles;
    gddc_top i_dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .OWN_SAMPLES(own_s), .OWN_TICKS(own_t), .PREV_SAMPLES(prev_s),
        .PREV_TICKS(prev_t), .IS_FIRST_MODULE(IS_FIRST), .MEAS_EPOCH(EPOCH),
        .PRI_I(pi), .PRI_Q(pq), .AUX_I(ai), .AUX_Q(aq));
    gddc_adc_model #(.CODE(3'h7)) i_own (.clk(CLK), .resetn(RESETN), .samples(own_s),
        .ticks(own_t));
    gddc_adc_model #(.CODE(3'h0)) i_prev (.clk(CLK), .resetn(RESETN), .samples(prev_s),
        .ticks(prev_t));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic settle();
        repeat (40) @(posedge CLK);
        @(negedge CLK);
    endtask : settle
    task automatic epoch();
        @(posedge CLK);
        EPOCH <= 1'b1;
        @(posedge CLK);
        EPOCH <= 1'b0;
    endtask : epoch
    task automatic t_regs();
        apb(0, gddc_pkg::GDDC_OFS_CTRL, 0);
        chk("ctrl", rd, 0);
        apb(0, gddc_pkg::GDDC_OFS_AUX_THR, 0);
        chk("thr", rd, {2'h0, gddc_pkg::GDDC_THR2_RST, gddc_pkg::GDDC_THR1_RST,
            gddc_pkg::GDDC_THR0_RST});
        apb(1, gddc_pkg::GDDC_OFS_STATUS, 32'hffffffff);
        apb(0, gddc_pkg::GDDC_OFS_STATUS, 0);
        chk("status", rd, 0);
        apb(1, 8'h20, 32'h1);
        chk("wr err", er, 1);
        apb(0, 8'h20, 0);
        chk("rd err", {er, rd[30:0]}, 32'h80000000);
    endtask : t_regs
    task automatic t_dc();
        settle();
        chk("pri", {pi, pq}, 6'o74);
        repeat (8) begin
            @(negedge CLK);
            chk("aux", {ai, aq}, 6'o74);
        end
    endtask : t_dc
    task automatic t_thr();
        apb(1, gddc_pkg::GDDC_OFS_PRI_THR, {2'h0, 10'h264, 10'h08f, 10'h047});
        settle();
        chk("t2 nine bits", pi, 3'h7);
        apb(1, gddc_pkg::GDDC_OFS_PRI_THR, {2'h0, 10'h0e8, 10'h08f, 10'h047});
        settle();
        chk("t2 level", pi, 3'h6);
        chk("aux own thr", ai, 3'h7);
        apb(1, gddc_pkg::GDDC_OFS_AUX_THR, {2'h0, 10'h0e8, 10'h08f, 10'h047});
        apb(1, gddc_pkg::GDDC_OFS_PRI_THR, {2'h0, 10'h0d7, 10'h08f, 10'h047});
        settle();
        chk("aux thr", {pi, ai}, 6'h3e);
        apb(1, gddc_pkg::GDDC_OFS_AUX_THR, {2'h0, 10'h0d7, 10'h08f, 10'h047});
    endtask : t_thr
    task automatic t_sel();
        apb(1, gddc_pkg::GDDC_OFS_CTRL, 1);
        settle();
        chk("pri prev", {pi, pq, ai}, 9'o047);
        apb(1, gddc_pkg::GDDC_OFS_CTRL, 2);
        settle();
        chk("aux prev", {pi, ai, aq}, 9'h1c4);
        apb(1, gddc_pkg::GDDC_OFS_CTRL, 3);
        IS_FIRST <= 1'b1;
        settle();
        chk("first own", {pi, ai}, 6'h3f);
        @(posedge CLK);
        IS_FIRST <= 1'b0;
        apb(1, gddc_pkg::GDDC_OFS_CTRL, 0);
    endtask : t_sel
    task automatic t_inc();
        apb(1, gddc_pkg::GDDC_OFS_PRI_INC, 32'h40);
        apb(1, gddc_pkg::GDDC_OFS_AUX_INC, 32'h1);
        apb(0, gddc_pkg::GDDC_OFS_STATUS, 0);
        chk("pending", {rd[22:16], rd[14:8], rd[1:0]}, 16'h0003);
        settle();
        chk("old inc", pi, 3'h7);
        epoch();
        apb(0, gddc_pkg::GDDC_OFS_STATUS, 0);
        chk("start", {rd[22:16], rd[14:8], rd[1:0]}, {7'h05, 7'h40, 2'h0});
        settle();
        chk("rotated", (pi === 3'h3 || pi === 3'h4), 1);
        apb(1, gddc_pkg::GDDC_OFS_PRI_INC, 0);
        apb(1, gddc_pkg::GDDC_OFS_AUX_INC, 0);
        epoch();
        apb(0, gddc_pkg::GDDC_OFS_STATUS, 0);
        chk("cleared", rd, 0);
    endtask : t_inc
    initial begin
        {RESETN, PSEL, PENABLE, PWRITE, IS_FIRST, EPOCH, PADDR, PWDATA} = '0;
        repeat (5) @(posedge CLK);
        RESETN <= 1'b1;
        t_regs();
        t_dc();
        t_thr();
        t_sel();
        t_inc();
        conclude();
    end
endmodule : gddc_top_tb
`default_nettype wire
